// File: rtl/dma_crc_checksum.v
// checksum engine fed by dma data words, registers over apb
// Operation
// - type bit 15 picks ip-header or lfsr
// - value write seeds the generator
// - value read returns result, undisturbed
// - lfsr: bits above length read zero
// - ip mode: result kept in low 16 bits
// - ip mode: upper 16 bits read zero
// - ip mode: ones-complement on write and read
// - ip mode ignores tap register
// - set tap bit xors feedback into stage
// - clear tap bit shifts straight through, except stage 0 which always takes the feedback
//
// The placing of the registers and the APB slave port were decided locally.
`include "crc_checksum_map.vh"
module dma_crc_checksum (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [31:0] dma_data,
    input  wire        dma_valid,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         dma_ready
);
    reg  [31:0] control_ff;
    reg  [31:0] value_ff;
    reg  [31:0] tap_ff;
    reg  [31:0] count_ff;
    reg  [31:0] nxt_value;
    reg  [31:0] nxt_prdata;
    reg         nxt_slverr;
    wire        ip_mode;
    wire [4:0]  polynomial_length;
    wire        enabled;
    wire [31:0] len_mask;
    wire [31:0] lfsr_next;
    wire [15:0] ip_next;
    wire [31:0] ip_in;
    wire        setup;
    wire        wr;
    wire        mapped;
    wire        take;

    assign ip_mode = control_ff[`TYPE_BIT];
    assign polynomial_length = control_ff[`POLYNOMIAL_LENGTH_MSB:`POLYNOMIAL_LENGTH_LSB];
    assign enabled = control_ff[`ENABLE_BIT];
    assign len_mask = {32{1'b1}} >> (5'd31 - polynomial_length);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign mapped = (paddr == `ADDR_CONTROL) | (paddr == `ADDR_VALUE) |
                    (paddr == `ADDR_TAP) | (paddr == `ADDR_STATUS);
    assign take = dma_valid & dma_ready & enabled;
    // optional byte order swap of incoming words
    assign ip_in = control_ff[`REVERSE_BIT] ?
        {dma_data[7:0], dma_data[15:8], dma_data[23:16], dma_data[31:24]}
        : dma_data;

    lfsr_word_step u_lfsr (
        .crc_in   (value_ff),
        .data_in  (ip_in),
        .tap_mask (tap_ff & len_mask),
        .polynomial_length     (polynomial_length),
        .crc_out  (lfsr_next)
    );

    ones_sum16 u_sum (
        .sum_in  (value_ff[15:0]),
        .data_in (ip_in),
        .sum_out (ip_next)
    );

    // software write wins over a dma word in the same cycle
    always @* begin
        nxt_value = value_ff;
        if (wr && paddr == `ADDR_VALUE) begin
            if (ip_mode)
                nxt_value = ~pwdata & `HALF_MASK;
            else
                nxt_value = pwdata;
        end else if (take) begin
            if (ip_mode)
                nxt_value = {16'h0000, ip_next};
            else
                nxt_value = lfsr_next;
        end
    end

    always @* begin
        nxt_prdata = `ZERO_WORD;
        nxt_slverr = 1'b0;
        case (paddr)
            `ADDR_CONTROL: nxt_prdata = control_ff;
            `ADDR_VALUE: begin
                if (ip_mode)
                    nxt_prdata = ~value_ff & `HALF_MASK;
                else
                    nxt_prdata = value_ff & len_mask;
            end
            `ADDR_TAP: nxt_prdata = tap_ff;
            `ADDR_STATUS: nxt_prdata = count_ff;
            default: nxt_slverr = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_ff <= `CONTROL_RESET;
            value_ff <= `VALUE_RESET;
            tap_ff <= `TAP_RESET;
            count_ff <= `ZERO_WORD;
            prdata <= `ZERO_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
            dma_ready <= 1'b0;
        end else begin
            value_ff <= nxt_value;
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? `ZERO_WORD : nxt_prdata;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
            if (wr && paddr == `ADDR_CONTROL)
                control_ff <= pwdata & `CONTROL_MASK;
            if (wr && paddr == `ADDR_TAP)
                tap_ff <= pwdata;
            if (wr && paddr == `ADDR_VALUE)
                count_ff <= `ZERO_WORD;
            else if (take)
                count_ff <= count_ff + 32'h00000001;
            dma_ready <= nxt_ready(enabled, psel & pwrite, paddr);
        end
    end

    // stall dma while software is writing the seed or while the engine is disabled
    function nxt_ready;
        input        en;
        input        w;
        input [11:0] a;
        begin
            nxt_ready = en & ~(w & (a == `ADDR_VALUE));
        end
    endfunction
endmodule

// File: rtl/crc_checksum_map.vh
// register map, field positions and reset values of the checksum engine
`ifndef CRC_CHECKSUM_MAP_VH
`define CRC_CHECKSUM_MAP_VH
`define ADDR_CONTROL      12'h000
`define ADDR_VALUE        12'h004
`define ADDR_TAP          12'h008
`define ADDR_STATUS       12'h00c
`define TYPE_BIT          15
`define POLYNOMIAL_LENGTH_LSB          8
`define POLYNOMIAL_LENGTH_MSB          12
`define ENABLE_BIT        7
`define REVERSE_BIT       0
`define VALUE_RESET       32'h00000000
`define TAP_RESET         32'h00000000
`define CONTROL_RESET     32'h00000000
`define CONTROL_MASK      32'h00009f81
`define HALF_MASK         32'h0000ffff
`define ZERO_WORD         32'h00000000
`define ADDR_W            12
`endif

// File: rtl/lfsr_word_step.v
// one 32-step pass of the programmable lfsr over a data word
`include "crc_checksum_map.vh"
module lfsr_word_step (
    input  wire [31:0] crc_in,
    input  wire [31:0] data_in,
    input  wire [31:0] tap_mask,
    input  wire [4:0]  polynomial_length,
    output wire [31:0] crc_out
);
    wire [31:0] stage [0:32];
    assign stage[0] = crc_in;
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_step
            wire        fb;
            wire [31:0] shifted;
            wire [31:0] len_mask;
            // feedback taken from the top active stage, msb of data first
            assign fb = stage[i][polynomial_length] ^ data_in[31 - i];
            assign len_mask = {32{1'b1}} >> (5'd31 - polynomial_length);
            // stage 0 always takes the feedback; others xor it where tapped
            assign shifted = {stage[i][30:0], 1'b0};
            assign stage[i+1] = (shifted ^ ({32{fb}} &
                                 (tap_mask | 32'h00000001))) & len_mask;
        end
    endgenerate
    assign crc_out = stage[32];
endmodule

// File: rtl/ones_sum16.v
// ones-complement 16-bit accumulation of a 32-bit word
module ones_sum16 (
    input  wire [15:0] sum_in,
    input  wire [31:0] data_in,
    output wire [15:0] sum_out
);
    wire [17:0] raw;
    wire [16:0] fold;
    assign raw = {2'b00, sum_in} + {2'b00, data_in[31:16]}
               + {2'b00, data_in[15:0]};
    assign fold = {1'b0, raw[15:0]} + {15'h0000, raw[17:16]};
    assign sum_out = fold[15:0] + {15'h0000, fold[16]};
endmodule

// File: dv/dma_crc_checksum_chk.sv
// port assertions for the checksum engine
`include "crc_checksum_map.vh"
module dma_crc_checksum_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire        pslverr,
    input wire        dma_ready,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ps;
    reg       typ_ff, en_ff;
    reg [4:0] len_ff;
    always @(posedge pclk or negedge presetn)
        if (!presetn) {typ_ff, en_ff, len_ff} <= 7'h00;
        else if (pready && pwrite && paddr == `ADDR_CONTROL)
            {typ_ff, en_ff, len_ff} <= {pwdata[15], pwdata[7], pwdata[12:8]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence rd_val_s; pready && !pwrite && paddr == `ADDR_VALUE; endsequence
    rdy_after_setup_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    rdy_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_on_unmapped_a: assert property (pready |-> pslverr ==
        (paddr > 12'h00c || paddr[1:0] != 2'b00))
        else $error("error flag wrong");
    err_read_zero_a: assert property (pready && pslverr |-> prdata == 0)
        else $error("refused read not zero");
    ip_upper_zero_a: assert property (rd_val_s ##0 typ_ff |-> !prdata[31:16])
        else $error("upper half not zero");
    lfsr_above_len_a: assert property (rd_val_s ##0 !typ_ff |->
        ((prdata >> len_ff) >> 1) == 0) else $error("bits above length");
    dma_idle_off_a: assert property (!en_ff && !$past(en_ff) |-> !dma_ready)
        else $error("ready while disabled");
    seed_blocks_dma_a: assert property (setup_s ##0 pwrite &&
        paddr == `ADDR_VALUE |=> !dma_ready) else $error("take during seed");
endmodule
bind dma_crc_checksum dma_crc_checksum_chk dma_crc_checksum_chk_i (.*);

// File: dv/dma_feeder.sv
// dma side model offering data words to the engine
module dma_feeder (
    input  wire        pclk,
    input  wire        dma_ready,
    output reg         dma_valid = 1'b0,
    output reg  [31:0] dma_data = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task send(input [31:0] w, input integer gap);
        begin
            repeat (gap) @(posedge pclk);
            dma_valid <= 1'b1;
            dma_data <= w;
            do @(posedge pclk); while (dma_ready !== 1'b1);
            dma_valid <= 1'b0;
            dma_data <= ~w;
        end
    endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the checksum engine
`include "crc_checksum_map.vh"
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd, exp_v, tap, w, w2;
    reg  [15:0] s;
    reg  [4:0]  l;
    wire [31:0] prdata, dma_data;
    wire        pready, pslverr, dma_ready, dma_valid;
    integer     seed = 32'h9d2c, num_errors = 0, tests_run = 0, k, j, m;
    dma_crc_checksum dma_crc_checksum_i (.*);
    dma_feeder dma_feeder_i (.*);
    initial forever #4 pclk = ~pclk;
    initial begin
        #400000 num_errors++;
        close_out;
    end
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    function [31:0] lf(input [31:0] c, d, t, input [4:0] n);
        integer i;
        reg     fb;
        begin
            for (i = 31; i >= 0; i--) begin
                fb = c[n] ^ d[i];
                c = ((c << 1) ^ ({32{fb}} & (t | 32'h1))) & ~(32'hfffffffe << n);
            end
            lf = c;
        end
    endfunction
    function [15:0] oc(input [15:0] a, input [31:0] d);
        reg [17:0] x;
        begin
            x = a + d[31:16] + d[15:0];
            x = x[15:0] + x[17:16];
            oc = x[15:0] + x[16];
        end
    endfunction
    task close_out;
        begin
            $display("errors=%0d checks=%0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `ADDR_VALUE, 0); `CK(rd, `VALUE_RESET)
        apb(0, `ADDR_TAP, 0); `CK(rd, `TAP_RESET)
        w = $random(seed);
        apb(1, `ADDR_TAP, w);
        apb(0, `ADDR_TAP, 0); `CK(rd, w)
        apb(0, 12'h010, 0); `CK({err, rd}, 33'h100000000)
        for (k = 0; k < 8; k++) begin
            m = k > 5;
            l = k == 0 ? 5'd31 : k == 1 ? 5'd0 : $random(seed);
            tap = $random(seed);
            w = $random(seed);
            apb(1, `ADDR_CONTROL, {16'h0, m[0], 2'b0, l, 1'b1, 6'h00, k[0]});
            apb(1, `ADDR_TAP, tap);
            apb(1, `ADDR_VALUE, w);
            exp_v = m ? {16'h0, w[15:0]} : w & ~(32'hfffffffe << l);
            s = ~w[15:0];
            for (j = 0; j < 5; j++) begin
                apb(0, `ADDR_VALUE, 0);
                `CK(rd, exp_v)
                if (j != 2) begin
                    w = $random(seed);
                    dma_feeder_i.send(w, 1 + k % 3);
                    // odd passes run with the byte swap turned on
                    w2 = k[0] ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
                    s = oc(s, w2);
                    exp_v = m ? {16'h0, ~s} : lf(exp_v, w2, tap, l);
                end
            end
            apb(0, `ADDR_STATUS, 0); `CK(rd, 32'h00000004)
        end
        // disabled engine must leave an offered word alone
        apb(1, `ADDR_CONTROL, 32'h00007f02);
        apb(0, `ADDR_CONTROL, 0); `CK(rd, 32'h00001f00)
        apb(1, `ADDR_VALUE, w);
        fork
            dma_feeder_i.send(~w, 1);
            begin
                repeat (6) @(posedge pclk);
                apb(0, `ADDR_VALUE, 0); `CK(rd, w)
                apb(1, `ADDR_CONTROL, 32'h00001f80);
            end
        join
        apb(0, `ADDR_VALUE, 0); `CK(rd, lf(w, ~w, tap, 5'd31))
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `ADDR_VALUE, 0); `CK(rd, `VALUE_RESET)
        apb(0, `ADDR_TAP, 0); `CK(rd, `TAP_RESET)
        close_out;
    end
endmodule
